/* hdl/gpi_action_pkg.sv */
/*
  Constants shared by the GPI trigger and action logic: action codes,
  selection codes, reset selections and fixed sizes.
  Assumes: one system clock, synchronous active-high reset.
*/
package gpi_action_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT  = 4;            // Video outputs
  localparam int NUM_QUAD = 4;            // Quadrants of the composite
  localparam int NUM_BKGD = 4;            // Background inputs
  localparam int ACT_W    = 4;            // Action code width
  localparam int IDX_W    = 2;            // Output / quadrant / background index
  localparam int SEL_W    = 3;            // Selection code width

  // ----------------------------------------------------------------
  // Action codes
  // ----------------------------------------------------------------
  typedef enum logic [ACT_W-1:0]
  {
    ACT_NONE       = 4'h0,
    ACT_OUT_QUAD   = 4'h1,
    ACT_OUT_BKGD   = 4'h2,
    ACT_OUT_CYCLE  = 4'h3,
    ACT_QUAD_BLACK = 4'h4,
    ACT_QUAD_BKGD  = 4'h5,
    ACT_QUAD_CYCLE = 4'h6,
    ACT_TALLY_1    = 4'h7,
    ACT_TALLY_2    = 4'h8
  } action_t;

  // ----------------------------------------------------------------
  // Selection codes: 0..3 pick a background, 4 is the special entry
  // (composite view for an output, black for a quadrant)
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_BKGD_A  = 3'h0;
  localparam logic [SEL_W-1:0] SEL_BKGD_B  = 3'h1;
  localparam logic [SEL_W-1:0] SEL_SPECIAL = 3'h4;
  localparam logic [SEL_W-1:0] SEL_LAST    = 3'h4;
  localparam logic [SEL_W-1:0] SEL_FIRST   = 3'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Outputs 1,2 composite, output 3 background A, output 4 background B
  localparam logic [NUM_OUT-1:0][SEL_W-1:0] OUT_SEL_RST =
    {SEL_BKGD_B, SEL_BKGD_A, SEL_SPECIAL, SEL_SPECIAL};
  // Quadrant n shows background n
  localparam logic [NUM_QUAD-1:0][SEL_W-1:0] QUAD_SEL_RST = {3'h3, 3'h2, 3'h1, 3'h0};
  // Synchroniser level after reset: idle-high input line
  localparam logic GPI_IDLE_RST = 1'h1;

endpackage

/* hdl/gpi_sync_detect.sv */
/*
  One GPI input: two-stage synchroniser, previous-sample register and
  polarity-aware active level and active-edge detection.
  Assumes: input asynchronous to clk_sys, held two periods per level.
*/
`timescale 1ns/1ps

module gpi_sync_detect
  import gpi_action_pkg::*;
(
  input  wire logic clk_sys,      // System clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic gpiPin,       // Raw GPI line
  input  wire logic polHigh,      // 1: high/rising, 0: low/falling
  output logic      activeLvl,    // Line sits at its active level
  output logic      activeEdge    // One-cycle pulse on active transition
);

  // ----------------------------------------------------------------
  // Synchroniser and history
  // ----------------------------------------------------------------
  logic syncA_r;                  // First stage, read only by syncB_r
  logic syncB_r;                  // Second stage, the current sample
  logic prev_r;                   // Previous synchronised sample

  // Two-stage synchroniser then one sample of history
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      syncA_r <= GPI_IDLE_RST;
      syncB_r <= GPI_IDLE_RST;
      prev_r  <= GPI_IDLE_RST;
    end
    else
    begin
      syncA_r <= gpiPin;
      syncB_r <= syncA_r;
      prev_r  <= syncB_r;
    end
  end

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  // active level follows polarity
  assign activeLvl  = polHigh ? syncB_r : ~syncB_r;
  // edge from current versus previous sample
  assign activeEdge = polHigh ? (syncB_r & ~prev_r) : (~syncB_r & prev_r);

endmodule

/* hdl/gpi_trigger_action_select.sv */
/*
  GPI trigger and action selection for a four-source multiviewer.
  Each GPI has an action, a target output or quadrant, a background
  choice, a trigger mode and a polarity; triggers steer the output
  selections, the quadrant selections and the on-screen tallies.
  Assumes: settings are static plain ports, GPI lines are driven by
  external control equipment, one clock, synchronous reset.
*/
`timescale 1ns/1ps

module gpi_trigger_action_select
  import gpi_action_pkg::*;
#(
  parameter int NUM_GPI = 4                                 // Number of GPI lines
)
(
  input  wire logic                               clk_sys,      // System clock
  input  wire logic                               rst,          // Synchronous reset
  input  wire logic [NUM_GPI-1:0]                 gpiIn,        // GPI lines
  input  wire logic [NUM_GPI-1:0][ACT_W-1:0]      gpiAction,    // Action per GPI
  input  wire logic [NUM_GPI-1:0][IDX_W-1:0]      gpiTarget,    // Output or quadrant
  input  wire logic [NUM_GPI-1:0][IDX_W-1:0]      gpiBkgd,      // Background choice
  input  wire logic [NUM_GPI-1:0]                 gpiLevelMode, // 1: level, 0: edge
  input  wire logic [NUM_GPI-1:0]                 gpiPolHigh,   // 1: high/rising
  output logic      [NUM_OUT-1:0][SEL_W-1:0]      outputSel,    // Per-output selection
  output logic      [NUM_QUAD-1:0][SEL_W-1:0]     quadSel,      // Per-quadrant selection
  output logic      [NUM_BKGD-1:0]                tally1,       // First tally per input
  output logic      [NUM_BKGD-1:0]                tally2,       // Second tally per input
  output logic      [NUM_GPI-1:0]                 gpiActive     // Synchronised active level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next entry of a cycle: backgrounds A..D, then the special entry
  function automatic logic [SEL_W-1:0] nextSel(input logic [SEL_W-1:0] cur);
    logic [SEL_W-1:0] res;
    res = SEL_FIRST;
    // step from current, wrap last to first
    if (cur < SEL_LAST)
    begin
      res = cur + 3'h1;
    end
    return res;
  endfunction

  // Background index widened to a selection code
  function automatic logic [SEL_W-1:0] bkgdSel(input logic [IDX_W-1:0] idx);
    return {1'b0, idx};
  endfunction

  // ----------------------------------------------------------------
  // Per-GPI detection
  // ----------------------------------------------------------------
  logic [NUM_GPI-1:0] edgeHit;    // Active transition, one cycle
  logic [NUM_GPI-1:0] doSet;      // Apply a set-style action this cycle

  genvar g;
  generate
    for (g = 0; g < NUM_GPI; g++)
    begin : gen_gpi
      // One synchroniser and detector per line
      gpi_sync_detect u_det
      (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .gpiPin     (gpiIn[g]),
        .polHigh    (gpiPolHigh[g]),
        .activeLvl  (gpiActive[g]),
        .activeEdge (edgeHit[g])
      );
      // edge acts once, level acts while held
      assign doSet[g] = gpiLevelMode[g] ? gpiActive[g] : edgeHit[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output selections
  // ----------------------------------------------------------------
  // Higher-numbered GPI wins when two act on one output in a cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // cycle positions start at their reset entry
      outputSel <= OUT_SEL_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_GPI; i++)
      begin
        unique case (gpiAction[i])
          ACT_OUT_QUAD:
          begin
            if (doSet[i])
            begin
              outputSel[gpiTarget[i]] <= SEL_SPECIAL;
            end
          end
          ACT_OUT_BKGD:
          begin
            if (doSet[i])
            begin
              outputSel[gpiTarget[i]] <= bkgdSel(gpiBkgd[i]);
            end
          end
          ACT_OUT_CYCLE:
          begin
            if (edgeHit[i])
            begin
              outputSel[gpiTarget[i]] <= nextSel(outputSel[gpiTarget[i]]);
            end
          end
          // none and other actions leave outputs alone
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Quadrant selections
  // ----------------------------------------------------------------
  // Same priority as the outputs: higher-numbered GPI wins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      quadSel <= QUAD_SEL_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_GPI; i++)
      begin
        unique case (gpiAction[i])
          ACT_QUAD_BLACK:
          begin
            if (doSet[i])
            begin
              quadSel[gpiTarget[i]] <= SEL_SPECIAL;
            end
          end
          ACT_QUAD_BKGD:
          begin
            if (doSet[i])
            begin
              quadSel[gpiTarget[i]] <= bkgdSel(gpiBkgd[i]);
            end
          end
          ACT_QUAD_CYCLE:
          begin
            if (edgeHit[i])
            begin
              quadSel[gpiTarget[i]] <= nextSel(quadSel[gpiTarget[i]]);
            end
          end
          // none and other actions leave quadrants alone
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Tallies
  // ----------------------------------------------------------------
  // Level mode: tally follows the active level; edge mode: toggles
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tally1 <= '0;
      tally2 <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_GPI; i++)
      begin
        unique case (gpiAction[i])
          ACT_TALLY_1:
          begin
            if (gpiLevelMode[i])
            begin
              tally1[gpiBkgd[i]] <= gpiActive[i];
            end
            else if (edgeHit[i])
            begin
              tally1[gpiBkgd[i]] <= ~tally1[gpiBkgd[i]];
            end
          end
          ACT_TALLY_2:
          begin
            if (gpiLevelMode[i])
            begin
              tally2[gpiBkgd[i]] <= gpiActive[i];
            end
            else if (edgeHit[i])
            begin
              tally2[gpiBkgd[i]] <= ~tally2[gpiBkgd[i]];
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

endmodule

/* verification/gpi_trigger_action_select_properties.sv */
/*
  Checker bound to the GPI trigger block; it judges GPI 0.
  Assumes: GPIs above 0 sit at no action while GPI 0 acts.
*/
`timescale 1ns/1ps

module gpi_trigger_action_select_checker
  import gpi_action_pkg::*;
#(
  parameter int NUM_GPI = 4
)
(
  input wire logic                           clk_sys,
  input wire logic                           rst,
  input wire logic [NUM_GPI-1:0]             gpiIn,
  input wire logic [NUM_GPI-1:0][ACT_W-1:0]  gpiAction,
  input wire logic [NUM_GPI-1:0][IDX_W-1:0]  gpiTarget,
  input wire logic [NUM_GPI-1:0][IDX_W-1:0]  gpiBkgd,
  input wire logic [NUM_GPI-1:0]             gpiLevelMode,
  input wire logic [NUM_GPI-1:0]             gpiPolHigh,
  input wire logic [NUM_OUT-1:0][SEL_W-1:0]  outputSel,
  input wire logic [NUM_QUAD-1:0][SEL_W-1:0] quadSel,
  input wire logic [NUM_BKGD-1:0]            tally1,
  input wire logic [NUM_BKGD-1:0]            tally2,
  input wire logic [NUM_GPI-1:0]             gpiActive
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [SEL_W-1:0] outT;   // Output aimed at by GPI 0
  logic [SEL_W-1:0] quadT;  // Quadrant aimed at by GPI 0
  logic             solo;   // Only GPI 0 has an action
  assign outT  = outputSel[gpiTarget[0]];
  assign quadT = quadSel[gpiTarget[0]];
  assign solo  = (gpiAction[NUM_GPI-1:1] == '0);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Active edge of GPI 0 in edge mode with action a
  sequence s_hit(logic [ACT_W-1:0] a);
    $rose(gpiActive[0]) && !gpiLevelMode[0] && solo && gpiAction[0] == a;
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_sync;
    !$past(rst) && !$past(rst, 2) |-> gpiActive[0] == ($past(gpiIn[0], 2) == gpiPolHigh[0]);
  endproperty
  a_sync: assert property (p_sync) else $error("GPI 0 active level wrong");
  property p_none;
    gpiAction == '0 |=> $stable(outputSel) && $stable(quadSel) && $stable({tally1, tally2});
  endproperty
  a_none: assert property (p_none) else $error("Idle GPI changed a selection");
  property p_outQuad;
    s_hit(ACT_OUT_QUAD) |=> outT == SEL_SPECIAL;
  endproperty
  a_outQuad: assert property (p_outQuad) else $error("Output not composite");
  property p_outBkgd;
    s_hit(ACT_OUT_BKGD) |=> outT == {1'b0, $past(gpiBkgd[0])};
  endproperty
  a_outBkgd: assert property (p_outBkgd) else $error("Output background wrong");
  property p_outCycle;
    s_hit(ACT_OUT_CYCLE) |=> outT == (($past(outT) == SEL_LAST) ? SEL_FIRST : $past(outT) + 3'h1);
  endproperty
  a_outCycle: assert property (p_outCycle) else $error("Output cycle step wrong");
  property p_quadBlack;
    s_hit(ACT_QUAD_BLACK) |=> quadT == SEL_SPECIAL;
  endproperty
  a_quadBlack: assert property (p_quadBlack) else $error("Quadrant not black");
  property p_quadCycle;
    s_hit(ACT_QUAD_CYCLE) |=> quadT == (($past(quadT) == SEL_LAST) ? SEL_FIRST : $past(quadT) + 3'h1);
  endproperty
  a_quadCycle: assert property (p_quadCycle) else $error("Quadrant cycle wrong");
  // Index taken from the cycle that set the tally, settings may move next
  property p_tally1Lvl;
    gpiLevelMode[0] && solo && gpiAction[0] == ACT_TALLY_1
      |=> tally1[$past(gpiBkgd[0])] == $past(gpiActive[0]);
  endproperty
  a_tally1Lvl: assert property (p_tally1Lvl) else $error("Tally one not level");
  property p_tally2Edge;
    s_hit(ACT_TALLY_2) |=> tally2[gpiBkgd[0]] != $past(tally2[gpiBkgd[0]]);
  endproperty
  a_tally2Edge: assert property (p_tally2Edge) else $error("Tally two not toggled");
endmodule

bind gpi_trigger_action_select gpi_trigger_action_select_checker #(.NUM_GPI(NUM_GPI)) chk
(
  .clk_sys(clk_sys), .rst(rst), .gpiIn(gpiIn), .gpiAction(gpiAction), .gpiTarget(gpiTarget),
  .gpiBkgd(gpiBkgd), .gpiLevelMode(gpiLevelMode), .gpiPolHigh(gpiPolHigh),
  .outputSel(outputSel), .quadSel(quadSel), .tally1(tally1), .tally2(tally2),
  .gpiActive(gpiActive)
);

/* verification/gpi_equipment.sv */
/*
  Model of the control equipment that drives the GPI lines.
  Assumes: lines idle high and change just after a clock edge.
*/
`timescale 1ns/1ps

module gpi_equipment
#(
  parameter int NUM_GPI = 4
)
(
  input  wire logic               clk_sys,  // System clock
  output logic      [NUM_GPI-1:0] gpiIn     // Driven GPI lines
);
  // ------------------------------------------------------------
  // Line driver
  // ------------------------------------------------------------
  initial gpiIn = '1;  // Idle high from time zero
  task automatic setLine(input int idx, input logic v);
    @(posedge clk_sys);
    #1 gpiIn[idx] = v;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
endmodule

/* verification/gpi_trigger_action_select_bench.sv */
/*
  Self-checking bench for the GPI trigger block; GPI 0 is exercised.
  Assumes: the other GPIs stay at no action throughout.
*/
`timescale 1ns/1ps

module gpi_trigger_action_select_bench
  import gpi_action_pkg::*;
;
  logic                          clk_sys, rst;
  logic [3:0]                    gpiIn, gpiLevelMode, gpiPolHigh, gpiActive;
  logic [3:0][ACT_W-1:0]         gpiAction;
  logic [3:0][IDX_W-1:0]         gpiTarget, gpiBkgd;
  logic [NUM_OUT-1:0][SEL_W-1:0] outputSel;
  logic [NUM_QUAD-1:0][SEL_W-1:0] quadSel;
  logic [NUM_BKGD-1:0]           tally1, tally2;
  int                            mismatches, checked;

  gpi_trigger_action_select #(.NUM_GPI(4)) DUT (.clk_sys(clk_sys), .rst(rst), .gpiIn(gpiIn),
    .gpiAction(gpiAction), .gpiTarget(gpiTarget), .gpiBkgd(gpiBkgd),
    .gpiLevelMode(gpiLevelMode), .gpiPolHigh(gpiPolHigh), .outputSel(outputSel),
    .quadSel(quadSel), .tally1(tally1), .tally2(tally2), .gpiActive(gpiActive));
  gpi_equipment #(.NUM_GPI(4)) EQ (.clk_sys(clk_sys), .gpiIn(gpiIn));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compare a selection, then a tally bit
  task automatic chkSel(input logic [SEL_W-1:0] exp, input logic [SEL_W-1:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic chkBit(input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Settings of GPI 0
  task automatic cfg(input action_t a, input logic [IDX_W-1:0] t, b, input logic lv, pol);
    @(posedge clk_sys);
    #1 gpiAction[0] = a;
    gpiTarget[0] = t;
    gpiBkgd[0] = b;
    gpiLevelMode[0] = lv;
    gpiPolHigh[0] = pol;
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      chkSel(OUT_SEL_RST[i], outputSel[i]);
      chkSel(QUAD_SEL_RST[i], quadSel[i]);
    end
    chkBit(1'b0, |{tally1, tally2});
    $display("reset values done");
  endtask
  task automatic t_none();
    cfg(ACT_NONE, 2'h0, 2'h3, 1'b0, 1'b0);
    EQ.setLine(0, 1'b0);
    chkSel(SEL_SPECIAL, outputSel[0]); // line ignored
    EQ.setLine(0, 1'b1);
    $display("no action done");
  endtask
  task automatic t_cycle();
    cfg(ACT_OUT_CYCLE, 2'h0, 2'h0, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      EQ.setLine(0, 1'b0);
      chkSel(SEL_W'(k % 5), outputSel[0]); // one step and wrap
      EQ.setLine(0, 1'b1);
      chkSel(SEL_W'(k % 5), outputSel[0]); // rise ignored
    end
    $display("output cycle done");
  endtask
  task automatic t_quad();
    cfg(ACT_QUAD_BLACK, 2'h2, 2'h0, 1'b0, 1'b0);
    EQ.setLine(0, 1'b0);
    chkSel(SEL_SPECIAL, quadSel[2]); // black quadrant
    EQ.setLine(0, 1'b1);
    cfg(ACT_QUAD_BKGD, 2'h2, 2'h1, 1'b0, 1'b0);
    EQ.setLine(0, 1'b0);
    chkSel(3'h1, quadSel[2]); // background quadrant
    EQ.setLine(0, 1'b1);
    cfg(ACT_QUAD_CYCLE, 2'h2, 2'h0, 1'b0, 1'b0);
    EQ.setLine(0, 1'b0);
    chkSel(3'h2, quadSel[2]); // step from current
    EQ.setLine(0, 1'b1);
    $display("quadrant actions done");
  endtask
  task automatic t_tally();
    cfg(ACT_TALLY_1, 2'h0, 2'h3, 1'b1, 1'b0);
    EQ.setLine(0, 1'b0);
    chkBit(1'b1, tally1[3]); // low level on
    EQ.setLine(0, 1'b1);
    chkBit(1'b0, tally1[3]); // follows level
    cfg(ACT_TALLY_2, 2'h0, 2'h1, 1'b0, 1'b0);
    EQ.setLine(0, 1'b0);
    chkBit(1'b1, tally2[1]); // toggled on edge
    EQ.setLine(0, 1'b1);
    chkBit(1'b1, tally2[1]); // rise ignored
    EQ.setLine(0, 1'b0);
    chkBit(1'b0, tally2[1]); // toggled again
    $display("tally done");
  endtask
  task automatic t_rise();
    cfg(ACT_OUT_BKGD, 2'h1, 2'h3, 1'b0, 1'b1);
    EQ.setLine(0, 1'b1);
    chkSel(3'h3, outputSel[1]); // rise shows background
    cfg(ACT_OUT_QUAD, 2'h1, 2'h0, 1'b0, 1'b1);
    EQ.setLine(0, 1'b0);
    chkSel(3'h3, outputSel[1]); // fall ignored
    EQ.setLine(0, 1'b1);
    chkSel(SEL_SPECIAL, outputSel[1]); // composite shown
    $display("rising edge done");
  endtask
  task automatic t_level();
    cfg(ACT_OUT_BKGD, 2'h2, 2'h1, 1'b1, 1'b1);
    EQ.setLine(0, 1'b1);
    chkSel(3'h1, outputSel[2]); // high level acts
    EQ.setLine(0, 1'b0);
    cfg(ACT_OUT_BKGD, 2'h2, 2'h2, 1'b1, 1'b0);
    EQ.setLine(0, 1'b0);
    chkSel(3'h2, outputSel[2]); // low level acts
    $display("level trigger done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    gpiAction = '0;
    gpiTarget = '0;
    gpiBkgd = '0;
    gpiLevelMode = '0;
    gpiPolHigh = '0;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_reset();
    t_none();
    t_cycle();
    t_quad();
    t_tally();
    t_rise();
    t_level();
    tally_and_finish();
  end
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
